// ===== rtl/serial_control_port_pkg.sv
/*
 * Constants and types shared by the serial control port.
 * Assumes an 8-bit register file of 32 entries behind the port.
 */
package serial_control_port_pkg;

    // -------------------------------------------------------------
    // instruction byte layout
    // -------------------------------------------------------------
    localparam int DIR_BIT      = 7;   // 1 = read, 0 = write
    localparam int COUNT_MSB    = 6;   // byte_count_field
    localparam int COUNT_LSB    = 5;
    localparam int ADDR_MSB     = 4;   // register_address_field
    localparam int ADDR_LSB     = 0;

    // -------------------------------------------------------------
    // widths and reset values
    // -------------------------------------------------------------
    localparam int ADDR_W       = 5;
    localparam int DATA_W       = 8;
    localparam int COUNT_W      = 2;
    localparam int BIT_CNT_W    = 3;
    localparam logic [2:0]  LAST_BIT    = 3'h7;
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [1:0]  COUNT_LAST  = 2'h0;

    // -------------------------------------------------------------
    // frame phases
    // -------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PH_INSTR,
        PH_DATA,
        PH_DONE
    } phase_e;

endpackage : serial_control_port_pkg

// ===== rtl/level_sync3.sv
/*
 * Three-stage level synchroniser.
 * Assumes a slowly changing input; the output follows once the second
 * and third stages agree.
 */
`timescale 1ns/1ps
module level_sync3
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_level,
    output logic      o_level
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic next_level;

    // -------------------------------------------------------------
    // agreement filter
    // -------------------------------------------------------------
    always_comb
    begin
        next_level = o_level;
        if (stage2 == stage3)
        begin
            next_level = stage3;
        end
    end

    // stage1 feeds only stage2
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            stage1  <= RESET_VALUE;
            stage2  <= RESET_VALUE;
            stage3  <= RESET_VALUE;
            o_level <= RESET_VALUE;
        end
        else
        begin
            stage1  <= i_level;
            stage2  <= stage1;
            stage3  <= stage2;
            o_level <= next_level;
        end
    end

endmodule : level_sync3

// ===== rtl/serial_control_port.sv
/*
 * Serial control port: instruction byte then one to four data bytes,
 * framed by serial_enable_n, clocked by the serial clock i_sclk.
 * Holds a 32 x 8 register image on the serial clock; each written byte
 * is also handed to the system clock domain as a write event.
 * Assumes i_sclk only runs while serial_enable_n is low.
 */
`timescale 1ns/1ps
module serial_control_port
    import serial_control_port_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_four_wire_select,
    output logic                   o_wr_valid,
    output logic [ADDR_W-1:0]      o_wr_addr,
    output logic [DATA_W-1:0]      o_wr_data,
    input  wire logic              i_sclk,
    input  wire logic              i_serial_enable_n,
    input  wire logic              i_sdio,
    output logic                   o_sdio,
    output logic                   o_sdio_oe,
    output logic                   o_alarm_or_serial_out,
    output logic                   o_alarm_or_serial_out_oe
);

    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    logic [DATA_W-1:0]    image [2**ADDR_W];
    logic                 frame_clear;
    logic                 four_wire;

    phase_e               phase;
    phase_e               next_phase;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [BIT_CNT_W-1:0] next_bit_cnt;
    logic [DATA_W-1:0]    shift_in;
    logic [DATA_W-1:0]    next_shift_in;
    logic                 is_read;
    logic                 next_is_read;
    logic [COUNT_W-1:0]   bytes_left;
    logic [COUNT_W-1:0]   next_bytes_left;
    logic [ADDR_W-1:0]    addr;
    logic [ADDR_W-1:0]    next_addr;

    logic                 commit;
    logic                 wr_toggle;
    logic                 next_wr_toggle;
    logic [ADDR_W-1:0]    hold_addr;
    logic [ADDR_W-1:0]    next_hold_addr;
    logic [DATA_W-1:0]    hold_data;
    logic [DATA_W-1:0]    next_hold_data;

    logic [DATA_W-1:0]    tx_shift;
    logic [DATA_W-1:0]    next_tx_shift;
    logic                 tx_drive;
    logic                 next_tx_drive;
    logic                 done_low;
    logic                 next_done_low;

    logic                 sys_toggle;
    logic                 sys_toggle_seen;
    logic                 next_wr_valid;
    logic [ADDR_W-1:0]    next_wr_addr;
    logic [DATA_W-1:0]    next_wr_data;

    // enable high or reset ends any frame at once
    assign frame_clear = !i_resetn | i_serial_enable_n;

    // -------------------------------------------------------------
    // mode select brought onto the serial clock
    // -------------------------------------------------------------
    level_sync3
    #(
        .RESET_VALUE (1'b0)
    )
    u_mode_sync
    (
        .i_clk    (i_sclk),
        .i_resetn (i_resetn),
        .i_level  (i_four_wire_select),
        .o_level  (four_wire)
    );

    // -------------------------------------------------------------
    // rising edge: instruction decode and write data capture
    // -------------------------------------------------------------
    always_comb
    begin
        next_shift_in   = {shift_in[DATA_W-2:0], i_sdio};
        next_bit_cnt    = bit_cnt + 3'h1;
        next_phase      = phase;
        next_is_read    = is_read;
        next_bytes_left = bytes_left;
        next_addr       = addr;
        commit          = 1'b0;
        case (phase)
            PH_INSTR:
            begin
                if (bit_cnt == LAST_BIT)
                begin
                    // first byte of the frame is the instruction
                    next_is_read    = next_shift_in[DIR_BIT];
                    next_bytes_left = next_shift_in[COUNT_MSB:COUNT_LSB];
                    next_addr       = next_shift_in[ADDR_MSB:ADDR_LSB];
                    next_phase      = PH_DATA;
                end
            end
            PH_DATA:
            begin
                if (bit_cnt == LAST_BIT)
                begin
                    commit = !is_read; // whole bytes only
                    if (bytes_left == COUNT_LAST)
                    begin
                        next_phase = PH_DONE;
                    end
                    else
                    begin
                        next_bytes_left = bytes_left - 2'h1;
                        next_addr       = addr - 5'h01;
                    end
                end
            end
            PH_DONE:
            begin
                next_bit_cnt = bit_cnt; // extra clocks are ignored
            end
            default:
            begin
                next_phase = PH_INSTR;
            end
        endcase
    end

    // frame state, cleared whenever the enable is high
    always_ff @(posedge i_sclk or posedge frame_clear)
    begin
        if (frame_clear)
        begin
            phase      <= PH_INSTR;
            bit_cnt    <= 3'h0;
            shift_in   <= 8'h00;
            is_read    <= 1'b0;
            bytes_left <= 2'h0;
            addr       <= 5'h00;
        end
        else
        begin
            phase      <= next_phase;
            bit_cnt    <= next_bit_cnt;
            shift_in   <= next_shift_in;
            is_read    <= next_is_read;
            bytes_left <= next_bytes_left;
            addr       <= next_addr;
        end
    end

    // -------------------------------------------------------------
    // register image and write hand-off word
    // -------------------------------------------------------------
    always_comb
    begin
        next_wr_toggle = wr_toggle;
        next_hold_addr = hold_addr;
        next_hold_data = hold_data;
        if (commit)
        begin
            next_wr_toggle = !wr_toggle;
            next_hold_addr = addr;
            next_hold_data = next_shift_in;
        end
    end

    // survives frame ends; only the chip reset clears it
    always_ff @(posedge i_sclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            for (int i = 0; i < 2**ADDR_W; i++)
            begin
                image[i] <= REG_RESET;
            end
            wr_toggle <= 1'b0;
            hold_addr <= 5'h00;
            hold_data <= 8'h00;
        end
        else
        begin
            if (commit)
            begin
                image[addr] <= next_shift_in;
            end
            wr_toggle <= next_wr_toggle;
            hold_addr <= next_hold_addr;
            hold_data <= next_hold_data;
        end
    end

    // -------------------------------------------------------------
    // falling edge: read data launch and pin drive
    // -------------------------------------------------------------
    always_comb
    begin
        next_tx_shift = {tx_shift[DATA_W-2:0], 1'b0};
        next_tx_drive = 1'b0; // input during instruction
        next_done_low = done_low;
        if (phase == PH_DATA && is_read)
        begin
            next_tx_drive = 1'b1;
            if (bit_cnt == 3'h0)
            begin
                next_tx_shift = image[addr]; // new byte, msb out first
            end
        end
        else if (phase == PH_DONE && is_read)
        begin
            next_done_low = 1'b1;
        end
    end

    // launched on the falling edge, dropped when enable rises
    always_ff @(negedge i_sclk or posedge frame_clear)
    begin
        if (frame_clear)
        begin
            tx_shift <= 8'h00;
            tx_drive <= 1'b0;
            done_low <= 1'b0;
        end
        else
        begin
            tx_shift <= next_tx_shift;
            tx_drive <= next_tx_drive;
            done_low <= next_done_low;
        end
    end

    // pin drive; wiring mode gates only the alarm pin
    assign o_sdio    = tx_shift[DATA_W-1];
    assign o_sdio_oe = tx_drive;
    assign o_alarm_or_serial_out = done_low ? 1'b0 : tx_shift[DATA_W-1];
    assign o_alarm_or_serial_out_oe = four_wire & (tx_drive | done_low);

    // -------------------------------------------------------------
    // write events into the system clock domain
    // -------------------------------------------------------------
    level_sync3
    #(
        .RESET_VALUE (1'b0)
    )
    u_toggle_sync
    (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_level  (wr_toggle),
        .o_level  (sys_toggle)
    );

    // held word is stable for a whole byte time after the toggle
    always_comb
    begin
        next_wr_valid = 1'b0;
        next_wr_addr  = o_wr_addr;
        next_wr_data  = o_wr_data;
        if (sys_toggle != sys_toggle_seen)
        begin
            next_wr_valid = 1'b1;
            next_wr_addr  = hold_addr;
            next_wr_data  = hold_data;
        end
    end

    // registered strobe and data
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sys_toggle_seen <= 1'b0;
            o_wr_valid      <= 1'b0;
            o_wr_addr       <= 5'h00;
            o_wr_data       <= 8'h00;
        end
        else
        begin
            sys_toggle_seen <= sys_toggle;
            o_wr_valid      <= next_wr_valid;
            o_wr_addr       <= next_wr_addr;
            o_wr_data       <= next_wr_data;
        end
    end

endmodule : serial_control_port

// ===== tb/serial_host.sv
/*
 * Host model that frames the serial link for the control port.
 * Assumes the bench resolves the data pin with its pull-down.
 */
`timescale 1ns/1ps
module serial_host
(
    input  wire logic i_sdio_wire,
    input  wire logic i_alarm_wire,
    output logic      o_sclk,
    output logic      o_serial_enable_n,
    output logic      o_sdio,
    output logic      o_sdio_oe
);
    localparam int HALF = 24;

    // idle link: clock still, enable high, data pin released
    initial
    begin
        o_sclk = 1'b0;
        o_serial_enable_n = 1'b1;
        o_sdio = 1'b0;
        o_sdio_oe = 1'b0;
    end

    // one frame; stops early when bit index ab is reached
    task automatic frame(input logic [7:0] ins, input logic [31:0] wd,
        input int ab, output logic [31:0] rs, output logic [31:0] ra,
        output logic al);
        int nb;
        nb = 8 * (int'(ins[6:5]) + 2);
        rs = '0;
        ra = '0;
        o_serial_enable_n = 1'b0;
        for (int i = 0; i < nb && i != ab; i++)
        begin
            o_sdio_oe = (i < 8) || !ins[7];
            o_sdio = (i < 8) ? ins[7 - i] : wd[39 - i];
            #HALF o_sclk = 1'b1;
            if (i >= 8)
            begin
                rs = {rs[30:0], i_sdio_wire};
                ra = {ra[30:0], i_alarm_wire};
            end
            #HALF o_sclk = 1'b0;
        end
        #HALF al = i_alarm_wire;
        o_serial_enable_n = 1'b1;
        o_sdio_oe = 1'b0;
        #HALF;
    endtask : frame
endmodule : serial_host

// ===== tb/serial_control_port_assertions.sv
/*
 * Checker on the serial control port top ports.
 * Assumes the mode select only changes between frames.
 */
`timescale 1ns/1ps
module serial_control_port_assertions
    import serial_control_port_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_resetn,
    input wire logic              i_four_wire_select,
    input wire logic              o_wr_valid,
    input wire logic [ADDR_W-1:0] o_wr_addr,
    input wire logic [DATA_W-1:0] o_wr_data,
    input wire logic              i_sclk,
    input wire logic              i_serial_enable_n,
    input wire logic              i_sdio,
    input wire logic              o_sdio,
    input wire logic              o_sdio_oe,
    input wire logic              o_alarm_or_serial_out,
    input wire logic              o_alarm_or_serial_out_oe
);
    logic [4:0]        gap;
    logic [ADDR_W-1:0] last_addr;

    // cycles since the last write event and its address
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            gap <= 5'h1f;
        else if (o_wr_valid)
            gap <= 5'h00;
        else if (gap != 5'h1f)
            gap <= gap + 5'h01;
        if (!i_resetn)
            last_addr <= '0;
        else if (o_wr_valid)
            last_addr <= o_wr_addr;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence idle2; i_serial_enable_n [*2]; endsequence
    sequence wr_pulse; o_wr_valid ##1 !o_wr_valid; endsequence

    sdio_idle_a: assert property (idle2 |-> !o_sdio_oe)
        else $error("data pin driven outside a frame");
    alarm_idle_a: assert property (idle2 |->
        !o_alarm_or_serial_out_oe) else $error("alarm pin held after frame");
    three_pin_a: assert property (o_alarm_or_serial_out_oe
        |-> i_four_wire_select) else $error("alarm pin driven in 3 pin");
    pins_match_a: assert property (o_sdio_oe &&
        o_alarm_or_serial_out_oe |-> o_sdio == o_alarm_or_serial_out)
        else $error("alarm pin differs from data pin");
    alarm_low_a: assert property (o_alarm_or_serial_out_oe &&
        !o_sdio_oe |-> !o_alarm_or_serial_out) else $error("alarm not low");
    wr_pulse_a: assert property (o_wr_valid |-> wr_pulse)
        else $error("write event longer than one cycle");
    addr_down_a: assert property (o_wr_valid && gap < 5'h10
        |-> o_wr_addr == ADDR_W'(last_addr - 1'b1))
        else $error("address did not count down");
    wr_hold_a: assert property (!o_wr_valid |->
        $stable(o_wr_addr) && $stable(o_wr_data))
        else $error("write outputs moved without an event");
endmodule : serial_control_port_assertions

bind serial_control_port serial_control_port_assertions i_chk (.*);

// ===== tb/testbench.sv
/*
 * Self-checking bench for the serial control port.
 * Assumes the host model and checker are compiled before it.
 */
`timescale 1ns/1ps
module testbench
    import serial_control_port_pkg::*;
;
    logic              i_clk, i_resetn, i_four_wire_select, i_sclk;
    logic              i_serial_enable_n, i_sdio, h_sdio, h_oe;
    logic              o_wr_valid, o_sdio, o_sdio_oe, alarm_w;
    logic              o_alarm_or_serial_out, o_alarm_or_serial_out_oe;
    logic              al_last = 1'b0;
    logic [ADDR_W-1:0] o_wr_addr;
    logic [DATA_W-1:0] o_wr_data;
    logic [7:0]        img [32];
    logic [12:0]       evq [$];
    int                mismatches, tests_run;

    // data pin pulled down; floating alarm pin shows the inverse level
    assign i_sdio = o_sdio_oe ? o_sdio : (h_oe ? h_sdio : 1'b0);
    assign alarm_w = o_alarm_or_serial_out_oe ? o_alarm_or_serial_out
                                              : ~al_last;
    always @(o_alarm_or_serial_out)
        if (o_alarm_or_serial_out_oe === 1'b1)
            al_last = o_alarm_or_serial_out;

    serial_control_port i_dut (.*);
    serial_host i_host (.i_sdio_wire(i_sdio), .i_alarm_wire(alarm_w),
        .o_sclk(i_sclk), .o_serial_enable_n(i_serial_enable_n),
        .o_sdio(h_sdio), .o_sdio_oe(h_oe));

    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // collect system write events
    always @(posedge i_clk)
        if (o_wr_valid === 1'b1)
            evq.push_back({o_wr_addr, o_wr_data});

    // host and device must never drive the data pin at once
    always @(posedge i_sclk)
        if (o_sdio_oe === 1'b1 && h_oe === 1'b1)
        begin
            mismatches++;
            $display("unexpected at %0t: pin clash %h %h", $time, o_sdio, h_sdio);
        end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    // bytes from the start address downward, first byte highest
    function automatic logic [31:0] expect_read(input int a, input int n);
        logic [31:0] ex;
        ex = '0;
        for (int k = 0; k <= n; k++)
            ex = {ex[23:0], img[a - k]};
        return ex;
    endfunction : expect_read

    // one frame with its checks; ab below zero means no early stop
    task automatic run(input logic rd, input logic [1:0] n,
        input logic [4:0] a, input logic [31:0] wd, input int ab);
        logic [31:0] rs, ra;
        logic        al;
        int          nc;
        evq.delete();
        i_host.frame({rd, n, a}, wd, ab, rs, ra, al);
        repeat (10) @(posedge i_clk);
        nc = (ab < 0) ? int'(n) + 1 : (ab - 8) / 8;
        if (!rd)
        begin
            check(32'(evq.size()), 32'(nc));
            for (int k = 0; k < nc && k < evq.size(); k++)
            begin
                img[a - k] = wd[31 - 8 * k -: 8];
                check(32'(evq[k]), {19'h0, 5'(a - k), img[a - k]});
            end
        end
        else
        begin
            check(rs, expect_read(a, n));
            if (i_four_wire_select)
            begin
                check(ra, expect_read(a, n));
                check(32'(al), 32'h0);
            end
            check(32'(evq.size()), 32'h0);
        end
    endtask : run

    initial
    begin
        logic [31:0] d0, d1;
        logic        d2;
        logic [1:0]  n;
        i_resetn = 1'b0;
        i_four_wire_select = 1'b0;
        mismatches = 0;
        tests_run = 0;
        foreach (img[i]) img[i] = REG_RESET;
        void'($urandom(32'hc134));
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk);
        run(1'b1, 2'h3, 5'h1f, 32'h0, -1);
        $display("test reset_read done");
        run(1'b0, 2'h3, 5'h03, $urandom, -1);
        run(1'b0, 2'h0, 5'h1f, $urandom, -1);
        for (int j = 0; j < 14; j++)
        begin
            n = 2'($urandom);
            run(1'b0, n, 5'(n + $urandom_range(0, 31 - n)), $urandom, -1);
        end
        $display("test writes done");
        run(1'b0, 2'h1, 5'h10, $urandom, 12);
        run(1'b0, 2'h2, 5'h08, $urandom, 5);
        run(1'b0, 2'h2, 5'h14, $urandom, 20);
        run(1'b1, 2'h3, 5'h10, 32'h0, -1);
        $display("test abort done");
        for (int m = 0; m < 2; m++)
        begin
            i_four_wire_select <= m[0];
            @(posedge i_clk);
            i_host.frame(8'h80, 32'h0, -1, d0, d1, d2);
            for (int j = 0; j < 8; j++)
            begin
                n = 2'($urandom);
                run(1'b1, n, 5'(n + $urandom_range(0, 31 - n)), 32'h0, -1);
            end
            $display("test read mode %0d done", m);
        end
        report_and_stop();
    end

    initial
    begin
        #1000000;
        mismatches++;
        report_and_stop();
    end
endmodule : testbench
